/* common/ett_pkg.sv */
// Purpose: constants, types and carriers for the event triggered transfer engine
// Assumes: plain register port, 16-bit register data, 32-bit memory master
// Notes: Behaviour
package ett_pkg;
	localparam int          NSRC      = 40;
	localparam logic [3:0]  OFF_EN4   = 4'h4;
	localparam logic [3:0]  OFF_CSR   = 4'h6;
	localparam logic [3:0]  OFF_BASE  = 4'h8;
	localparam int          CSR_NMI   = 10;
	localparam int          CSR_AE    = 9;
	localparam int          CSR_SWEN  = 8;
	localparam int          MD_DTS    = 7;
	localparam int          MD_CHAIN_ENABLE   = 6;
	localparam int          MD_IRQ_EVERY_TRANSFER  = 5;
	localparam int          MD_NMI_FINISH_MODE   = 4;
	localparam logic [1:0]  SZ_BYTE   = 2'h0;
	localparam logic [1:0]  SZ_WORD   = 2'h1;
	localparam logic [1:0]  SZ_LONG   = 2'h2;
	localparam logic [1:0]  MODE_NORM = 2'h0;
	localparam logic [1:0]  MODE_REP  = 2'h1;
	localparam logic [1:0]  MODE_BLK  = 2'h2;
	localparam logic [15:0] VEC_BASE  = 16'h0400;
	localparam logic [31:0] OFS_W1    = 32'h0000_0004;
	localparam logic [31:0] OFS_SAR   = 32'h0000_0008;
	localparam logic [31:0] OFS_DAR   = 32'h0000_000C;
	localparam logic [31:0] DESC_NEXT = 32'h0000_0010;
	localparam logic [15:0] CNT_ONE   = 16'h0001;

	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_VEC  = 4'h1,
		S_W0   = 4'h2,
		S_W1   = 4'h3,
		S_SAR  = 4'h4,
		S_DAR  = 4'h5,
		S_RD   = 4'h6,
		S_WR   = 4'h7,
		S_WB0  = 4'h8,
		S_WBS  = 4'h9,
		S_WBD  = 4'hA
	} ett_state_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} ett_mem_req_t;

	typedef struct packed {
		logic        ack;
		logic        err;
		logic [31:0] rdata;
	} ett_mem_rsp_t;
endpackage

/* logic/ett_engine.sv */
// Purpose: event triggered transfer engine with in-memory descriptors
// Assumes: memory data right-justified; mode word in upper half of first longword
// Notes: enable and request vectors use register layout, index = reg*8 + bit
`timescale 1ns/1ps
`default_nettype none
module ett_engine
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  standby_i,
	input  wire logic                  nmi_pin_i,
	input  wire logic [3:0]            reg_addr_i,
	input  wire logic [15:0]           reg_wdata_i,
	input  wire logic                  reg_wr_i,
	input  wire logic                  reg_rd_i,
	output logic      [15:0]           reg_rdata_o,
	input  wire logic [ett_pkg::NSRC-1:0] src_req_i,
	output logic      [ett_pkg::NSRC-1:0] src_clr_o,
	output logic      [ett_pkg::NSRC-1:0] cpu_irq_o,
	output logic                       sw_irq_o,
	output ett_pkg::ett_mem_req_t      mem_req_o,
	input  wire ett_pkg::ett_mem_rsp_t mem_rsp_i,
	output logic                       busy_o
);
	import ett_pkg::*;

	function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] m,
		input logic [1:0] sz);
		logic [31:0] inc;
		inc = (sz == SZ_LONG) ? 32'h0000_0004 : ((sz == SZ_WORD) ? 32'h0000_0002 : 32'h0000_0001);
		if (!m[1])
			step_addr = a;
		else if (m[0])
			step_addr = a - inc;
		else
			step_addr = a + inc;
	endfunction

	function automatic logic aligned(input logic [31:0] a, input logic [1:0] sz);
		case (sz)
			SZ_BYTE: aligned = 1'b1;
			SZ_WORD: aligned = !a[0];
			SZ_LONG: aligned = (a[1:0] == 2'h0);
			default: aligned = 1'b0;
		endcase
	endfunction

	// nmi pin synchroniser; edge taken only once stages two and three agree
	logic [2:0] nmi_s_ff;
	logic [2:0] nxt_nmi_s;
	logic       nmi_lvl_ff;
	logic       nxt_nmi_lvl;
	logic       nmi_evt_ff;
	logic       nxt_nmi_evt;

	always_comb
	begin
		nxt_nmi_s = {nmi_s_ff[1:0], nmi_pin_i};
		nxt_nmi_lvl = (nmi_s_ff[1] == nmi_s_ff[2]) ? nmi_s_ff[2] : nmi_lvl_ff;
		nxt_nmi_evt = nxt_nmi_lvl & ~nmi_lvl_ff;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			nmi_s_ff <= 3'h0;
			nmi_lvl_ff <= 1'b0;
			nmi_evt_ff <= 1'b0;
		end
		else
		begin
			nmi_s_ff <= nxt_nmi_s;
			nmi_lvl_ff <= nxt_nmi_lvl;
			nmi_evt_ff <= nxt_nmi_evt;
		end
	end

	ett_state_t      state_ff, nxt_state;
	ett_mem_req_t    req_ff, nxt_req;
	logic [NSRC-1:0] en_ff, nxt_en;
	logic [NSRC-1:0] snap_ff, nxt_snap;
	logic [NSRC-1:0] arm_ff, nxt_arm;
	logic [NSRC-1:0] clr_ff, nxt_clr;
	logic [NSRC-1:0] irq_ff, nxt_irq;
	logic            nmi_stop_flag_ff, nxt_nmi_stop_flag;
	logic            ae_ff, nxt_ae;
	logic            swen_ff, nxt_swen;
	logic [7:0]      vec_ff, nxt_vec;
	logic [2:0]      csr_arm_ff, nxt_csr_arm;
	logic            pend_ff, nxt_pend;
	logic [15:0]     base_ff, nxt_base;
	logic [15:0]     rdata_ff, nxt_rdata;
	logic            swirq_ff, nxt_swirq;
	logic [15:0]     md_ff, nxt_md;
	logic [15:0]     cnt_ff, nxt_cnt;
	logic [31:0]     iar_ff, nxt_iar;
	logic [31:0]     sar_ff, nxt_sar;
	logic [31:0]     dar_ff, nxt_dar;
	logic [31:0]     start_ff, nxt_start;
	logic [31:0]     data_ff, nxt_data;
	logic [31:0]     blk_ff, nxt_blk;
	logic [15:0]     ucnt_ff, nxt_ucnt;
	logic [5:0]      src_ff, nxt_src;
	logic            sw_ff, nxt_sw;
	logic            raise_ff, nxt_raise;

	logic [NSRC-1:0] hot;
	logic            hw_any;
	logic [5:0]      hw_idx;
	logic [5:0]      hw_rank;
	logic [31:0]     nsar;
	logic [31:0]     ndar;
	logic [1:0]      mode;
	logic [1:0]      sz;
	logic            ack;
	int              r;
	int              idx;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_en = en_ff;
		nxt_snap = snap_ff;
		nxt_arm = arm_ff;
		nxt_clr = '0;
		nxt_irq = '0;
		nxt_nmi_stop_flag = nmi_stop_flag_ff;
		nxt_ae = ae_ff;
		nxt_swen = swen_ff;
		nxt_vec = vec_ff;
		nxt_csr_arm = csr_arm_ff;
		nxt_pend = pend_ff;
		nxt_base = base_ff;
		nxt_rdata = 16'h0000;
		nxt_swirq = 1'b0;
		nxt_md = md_ff;
		nxt_cnt = cnt_ff;
		nxt_iar = iar_ff;
		nxt_sar = sar_ff;
		nxt_dar = dar_ff;
		nxt_start = start_ff;
		nxt_data = data_ff;
		nxt_blk = blk_ff;
		nxt_ucnt = ucnt_ff;
		nxt_src = src_ff;
		nxt_sw = sw_ff;
		nxt_raise = raise_ff;
		mode = md_ff[11:10];
		sz = md_ff[9:8];
		ack = req_ff.valid & mem_rsp_i.ack;
		nsar = step_addr(sar_ff, md_ff[15:14], sz);
		ndar = step_addr(dar_ff, md_ff[13:12], sz);
		hot = src_req_i & en_ff;
		hw_any = |hot;
		hw_idx = 6'h00;
		hw_rank = 6'h00;
		// rank 0 is register 0 bit 7; the last hit in the loop is the most urgent
		for (int q = NSRC - 1; q >= 0; q--)
		begin
			idx = (q / 8) * 8 + 7 - (q % 8);
			if (hot[idx])
			begin
				hw_idx = 6'(idx);
				hw_rank = 6'(q);
			end
		end

		case (state_ff)
			S_IDLE:
			begin
				// no start while either stop flag is up
				if (!nmi_stop_flag_ff && !ae_ff && !standby_i)
				begin
					if (hw_any)
					begin
						nxt_src = hw_idx;
						nxt_sw = 1'b0;
						nxt_start = {16'h0000, VEC_BASE + {9'h000, hw_rank, 1'b0}};
						nxt_state = S_VEC;
					end
					else if (pend_ff && swen_ff)
					begin
						nxt_sw = 1'b1;
						nxt_pend = 1'b0;
						nxt_start = {16'h0000, VEC_BASE + {8'h00, vec_ff}};
						nxt_state = S_VEC;
					end
				end
			end
			S_VEC:
				if (ack)
				begin
					nxt_start = {base_ff, mem_rsp_i.rdata[15:0]};
					nxt_state = (mem_rsp_i.rdata[1:0] == 2'h0) ? S_W0 : S_IDLE;
					nxt_ae = ae_ff | (mem_rsp_i.rdata[1:0] != 2'h0);
				end
			S_W0:
				if (ack)
				begin
					nxt_md = mem_rsp_i.rdata[31:16];
					nxt_cnt = mem_rsp_i.rdata[15:0];
					nxt_state = S_W1;
				end
			S_W1:
				if (ack)
				begin
					nxt_iar = mem_rsp_i.rdata;
					nxt_ucnt = mem_rsp_i.rdata[15:0];
					nxt_state = S_SAR;
				end
			S_SAR:
				if (ack)
				begin
					nxt_sar = mem_rsp_i.rdata;
					nxt_state = S_DAR;
				end
			S_DAR:
				if (ack)
				begin
					nxt_dar = mem_rsp_i.rdata;
					nxt_blk = md_ff[MD_DTS] ? sar_ff : mem_rsp_i.rdata;
					// misaligned addresses or reserved codes count as an address error
					if (!aligned(sar_ff, sz) || !aligned(mem_rsp_i.rdata, sz) ||
						(mode == 2'h3))
					begin
						nxt_ae = 1'b1;
						nxt_state = S_IDLE;
					end
					else if (nmi_stop_flag_ff && !md_ff[MD_NMI_FINISH_MODE])
						nxt_state = S_IDLE;
					else
						nxt_state = S_RD;
				end
			S_RD:
				if (ack)
				begin
					nxt_data = mem_rsp_i.rdata;
					nxt_state = S_WR;
				end
			S_WR:
				if (ack)
				begin
					nxt_sar = nsar;
					nxt_dar = ndar;
					if (mode == MODE_BLK && ucnt_ff != CNT_ONE)
					begin
						nxt_ucnt = ucnt_ff - CNT_ONE;
						nxt_state = (nmi_stop_flag_ff && !md_ff[MD_NMI_FINISH_MODE]) ? S_IDLE : S_RD;
					end
					else
					begin
						nxt_state = S_WB0;
						if (mode == MODE_BLK)
						begin
							nxt_sar = md_ff[MD_DTS] ? blk_ff : nsar;
							nxt_dar = md_ff[MD_DTS] ? ndar : blk_ff;
						end
						if (mode == MODE_REP)
						begin
							if (cnt_ff[7:0] == 8'h01)
							begin
								nxt_cnt = {cnt_ff[15:8], cnt_ff[15:8]};
								nxt_sar = md_ff[MD_DTS] ? iar_ff : nsar;
								nxt_dar = md_ff[MD_DTS] ? ndar : iar_ff;
							end
							else
								nxt_cnt = {cnt_ff[15:8], cnt_ff[7:0] - 8'h01};
						end
						else
							nxt_cnt = cnt_ff - CNT_ONE;
						nxt_raise = md_ff[MD_IRQ_EVERY_TRANSFER] | (mode != MODE_REP && cnt_ff == CNT_ONE);
					end
				end
			S_WB0:
				if (ack)
					nxt_state = S_WBS;
			S_WBS:
				if (ack)
					nxt_state = S_WBD;
			S_WBD:
				if (ack)
				begin
					if (md_ff[MD_CHAIN_ENABLE] && !nmi_stop_flag_ff)
					begin
						nxt_start = start_ff + DESC_NEXT;
						nxt_state = S_W0;
					end
					else
					begin
						nxt_state = S_IDLE;
						if (sw_ff)
						begin
							nxt_swirq = raise_ff;
							nxt_swen = raise_ff;
						end
						else if (raise_ff)
						begin
							nxt_irq[src_ff] = 1'b1;
							nxt_en[src_ff] = 1'b0;
						end
						else
							nxt_clr[src_ff] = 1'b1;
					end
				end
			default:
				nxt_state = S_IDLE;
		endcase
		if (ack && mem_rsp_i.err && state_ff != S_IDLE)
		begin
			nxt_ae = 1'b1;
			nxt_state = S_IDLE;
		end

		// register port, after engine updates so software writes override them
		r = int'(reg_addr_i[2:0]);
		if (reg_rd_i)
		begin
			if (reg_addr_i <= OFF_EN4)
			begin
				nxt_rdata = {8'h00, en_ff[r*8 +: 8]};
				nxt_snap[r*8 +: 8] = en_ff[r*8 +: 8];
				nxt_arm[r*8 +: 8] = 8'hFF;
			end
			else if (reg_addr_i == OFF_CSR)
			begin
				nxt_rdata = {5'h00, nmi_stop_flag_ff, ae_ff, swen_ff, vec_ff};
				nxt_csr_arm = {nmi_stop_flag_ff, ae_ff, swen_ff};
			end
			else if (reg_addr_i == OFF_BASE)
				nxt_rdata = base_ff;
		end
		if (reg_wr_i)
		begin
			if (reg_addr_i <= OFF_EN4)
			begin
				for (int b = 0; b < 8; b++)
					if (arm_ff[r*8+b] && reg_wdata_i[b] != snap_ff[r*8+b])
						nxt_en[r*8+b] = reg_wdata_i[b];
				nxt_arm[r*8 +: 8] = 8'h00;
			end
			else if (reg_addr_i == OFF_CSR)
			begin
				if (csr_arm_ff[2] && !reg_wdata_i[CSR_NMI])
					nxt_nmi_stop_flag = 1'b0;
				if (csr_arm_ff[1] && !reg_wdata_i[CSR_AE])
					nxt_ae = 1'b0;
				if (reg_wdata_i[CSR_SWEN])
				begin
					nxt_swen = 1'b1;
					nxt_pend = 1'b1;
				end
				else if (csr_arm_ff[0])
					nxt_swen = 1'b0;
				if (!swen_ff)
					nxt_vec = reg_wdata_i[7:0];
				nxt_csr_arm = 3'h0;
			end
			else if (reg_addr_i == OFF_BASE)
				nxt_base = reg_wdata_i;
		end
		// nmi event and bus error sets win over a software clear in the same cycle; standby still clears both flags
		if (nmi_evt_ff)
			nxt_nmi_stop_flag = 1'b1;
		if (ack && mem_rsp_i.err && state_ff != S_IDLE)
			nxt_ae = 1'b1;
		if (standby_i)
		begin
			nxt_en = '0;
			nxt_arm = '0;
			nxt_nmi_stop_flag = 1'b0;
			nxt_ae = 1'b0;
			nxt_swen = 1'b0;
			nxt_vec = 8'h00;
			nxt_csr_arm = 3'h0;
			nxt_pend = 1'b0;
			nxt_state = S_IDLE;
		end

		// bus request follows the next state, held until acknowledged
		nxt_req.valid = (nxt_state != S_IDLE);
		nxt_req.write = (nxt_state == S_WR) || (nxt_state == S_WB0) ||
			(nxt_state == S_WBS) || (nxt_state == S_WBD);
		nxt_req.size = SZ_LONG;
		nxt_req.addr = nxt_start;
		nxt_req.wdata = 32'h0000_0000;
		case (nxt_state)
			S_VEC: nxt_req.size = SZ_WORD;
			S_W1: nxt_req.addr = nxt_start + OFS_W1;
			S_SAR: nxt_req.addr = nxt_start + OFS_SAR;
			S_DAR: nxt_req.addr = nxt_start + OFS_DAR;
			S_RD:
			begin
				nxt_req.size = nxt_md[9:8];
				nxt_req.addr = nxt_sar;
			end
			S_WR:
			begin
				nxt_req.size = nxt_md[9:8];
				nxt_req.addr = nxt_dar;
				nxt_req.wdata = nxt_data;
			end
			S_WB0: nxt_req.wdata = {nxt_md, nxt_cnt};
			S_WBS:
			begin
				nxt_req.addr = nxt_start + OFS_SAR;
				nxt_req.wdata = nxt_sar;
			end
			S_WBD:
			begin
				nxt_req.addr = nxt_start + OFS_DAR;
				nxt_req.wdata = nxt_dar;
			end
			default: nxt_req.size = SZ_LONG;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_ff <= S_IDLE;
			req_ff <= '0;
			en_ff <= '0;
			snap_ff <= '0;
			arm_ff <= '0;
			clr_ff <= '0;
			irq_ff <= '0;
			nmi_stop_flag_ff <= 1'b0;
			ae_ff <= 1'b0;
			swen_ff <= 1'b0;
			vec_ff <= 8'h00;
			csr_arm_ff <= 3'h0;
			pend_ff <= 1'b0;
			rdata_ff <= 16'h0000;
			swirq_ff <= 1'b0;
			md_ff <= 16'h0000;
			cnt_ff <= 16'h0000;
			iar_ff <= 32'h0000_0000;
			sar_ff <= 32'h0000_0000;
			dar_ff <= 32'h0000_0000;
			start_ff <= 32'h0000_0000;
			data_ff <= 32'h0000_0000;
			blk_ff <= 32'h0000_0000;
			ucnt_ff <= 16'h0000;
			src_ff <= 6'h00;
			sw_ff <= 1'b0;
			raise_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			req_ff <= nxt_req;
			en_ff <= nxt_en;
			snap_ff <= nxt_snap;
			arm_ff <= nxt_arm;
			clr_ff <= nxt_clr;
			irq_ff <= nxt_irq;
			nmi_stop_flag_ff <= nxt_nmi_stop_flag;
			ae_ff <= nxt_ae;
			swen_ff <= nxt_swen;
			vec_ff <= nxt_vec;
			csr_arm_ff <= nxt_csr_arm;
			pend_ff <= nxt_pend;
			rdata_ff <= nxt_rdata;
			swirq_ff <= nxt_swirq;
			md_ff <= nxt_md;
			cnt_ff <= nxt_cnt;
			iar_ff <= nxt_iar;
			sar_ff <= nxt_sar;
			dar_ff <= nxt_dar;
			start_ff <= nxt_start;
			data_ff <= nxt_data;
			blk_ff <= nxt_blk;
			ucnt_ff <= nxt_ucnt;
			src_ff <= nxt_src;
			sw_ff <= nxt_sw;
			raise_ff <= nxt_raise;
		end
	end

	// base keeps its content across every reset; software must load it first
	always_ff @(posedge clk_i)
	begin
		base_ff <= nxt_base;
	end

	assign reg_rdata_o = rdata_ff;
	assign src_clr_o = clr_ff;
	assign cpu_irq_o = (src_req_i & ~en_ff) | irq_ff;
	assign sw_irq_o = swirq_ff;
	assign mem_req_o = req_ff;
	assign busy_o = (state_ff != S_IDLE);
endmodule
`default_nettype wire

/* verif/ett_mem_model.sv */
// Purpose: behavioural memory on the engine's master port
// Assumes: big-endian bytes, data right-justified, one request held at a time
// Notes: unwritten bytes read as zero; slow_i adds wait states between answers
`timescale 1ns/1ps
`default_nettype none
module ett_mem_model
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  slow_i,
	input  wire ett_pkg::ett_mem_req_t req_i,
	output ett_pkg::ett_mem_rsp_t      rsp_o
);
	import ett_pkg::*;
	logic [7:0] m [logic [31:0]];
	int         wait_cnt;

	task automatic put(input logic [31:0] a, input logic [31:0] v, input int n);
		for (int i = 0; i < n; i++)
			m[a + i] = v[8 * (n - 1 - i) +: 8];
	endtask

	function automatic logic [31:0] get(input logic [31:0] a, input int n);
		logic [31:0] v;
		v = 32'h0000_0000;
		for (int i = 0; i < n; i++)
			v = {v[23:0], m.exists(a + i) ? m[a + i] : 8'h00};
		return v;
	endfunction

	initial rsp_o = '0;

	// read data is not held once the answer is gone, so it toggles every cycle
	always @(posedge clk_i)
	begin
		rsp_o.ack <= 1'b0;
		rsp_o.err <= 1'b0;
		rsp_o.rdata <= ~rsp_o.rdata;
		if (rst_i)
			wait_cnt = 0;
		else if (req_i.valid && !rsp_o.ack)
		begin
			if (wait_cnt > 0)
				wait_cnt = wait_cnt - 1;
			else
			begin
				if (req_i.write)
					put(req_i.addr, req_i.wdata, 1 << req_i.size);
				rsp_o.rdata <= get(req_i.addr, 1 << req_i.size);
				rsp_o.ack <= 1'b1;
				wait_cnt = slow_i ? 3 : 0;
			end
		end
	end
endmodule
`default_nettype wire

/* verif/ett_engine_assertions.sv */
// Purpose: port-level checks of the transfer engine
// Assumes: one clock, synchronous active-high reset
// Notes: flag blocking is judged from what a status read shows
`timescale 1ns/1ps
`default_nettype none
module ett_engine_assertions
(
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     standby_i,
	input  wire logic [3:0]               reg_addr_i,
	input  wire logic                     reg_wr_i,
	input  wire logic                     reg_rd_i,
	input  wire logic [15:0]              reg_rdata_o,
	input  wire logic [ett_pkg::NSRC-1:0] src_clr_o,
	input  wire logic [ett_pkg::NSRC-1:0] cpu_irq_o,
	input  wire logic                     sw_irq_o,
	input  wire ett_pkg::ett_mem_req_t    mem_req_o,
	input  wire ett_pkg::ett_mem_rsp_t    mem_rsp_i,
	input  wire logic                     busy_o
);
	import ett_pkg::*;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_csr_top_zero: assert property (
		$past(reg_rd_i) && $past(reg_addr_i) == OFF_CSR |-> reg_rdata_o[15:11] == 5'h00)
		else $error("status read shows nonzero top bits");
	a_enable_byte: assert property (
		$past(reg_rd_i) && $past(reg_addr_i) <= 4'h4 |-> reg_rdata_o[15:8] == 8'h00)
		else $error("enable register wider than a byte");
	a_req_hold: assert property (
		mem_req_o.valid && !mem_rsp_i.ack && !standby_i |=> $stable(mem_req_o))
		else $error("memory request changed before ack");
	a_req_busy: assert property (mem_req_o.valid |-> busy_o)
		else $error("memory request while idle");
	a_vector_first: assert property (
		$rose(busy_o) |-> ##[0:1] (mem_req_o.valid && !mem_req_o.write
			&& mem_req_o.size == SZ_WORD && mem_req_o.addr[31:8] == 24'h00_0004))
		else $error("activation did not start with a vector fetch");
	a_nmi_blocks: assert property (
		$past(reg_rd_i) && $past(reg_addr_i) == OFF_CSR && reg_rdata_o[CSR_NMI]
			&& !busy_o && !reg_wr_i |=> !busy_o)
		else $error("transfer started with nmi flag set");
	a_ae_blocks: assert property (
		$past(reg_rd_i) && $past(reg_addr_i) == OFF_CSR && reg_rdata_o[CSR_AE]
			&& !busy_o && !reg_wr_i ##1 !reg_wr_i |=> !busy_o)
		else $error("transfer started with address error flag set");
	a_sw_irq_end: assert property (sw_irq_o |-> $past(busy_o) ##1 !sw_irq_o)
		else $error("software interrupt not a pulse after a transfer");
	a_clr_irq_excl: assert property ((src_clr_o & cpu_irq_o) == '0)
		else $error("source cleared and interrupted at once");
endmodule

bind ett_engine ett_engine_assertions i_chk
(
	.clk_i(clk_i), .rst_i(rst_i), .standby_i(standby_i), .reg_addr_i(reg_addr_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.src_clr_o(src_clr_o), .cpu_irq_o(cpu_irq_o), .sw_irq_o(sw_irq_o),
	.mem_req_o(mem_req_o), .mem_rsp_i(mem_rsp_i), .busy_o(busy_o)
);
`default_nettype wire

/* verif/tb.sv */
// Purpose: self-checking bench for the transfer engine
// Assumes: memory model answers every request
// Notes: register reads and vector fetches are checked from queues
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ett_pkg::*;
	logic               clk_i = 1'b0;
	logic               rst_i = 1'b1;
	logic               standby_i = 1'b0;
	logic               nmi_pin_i = 1'b0;
	logic               slow = 1'b0;
	logic [3:0]         reg_addr_i = 4'h0;
	logic [15:0]        reg_wdata_i = 16'h0000;
	logic               reg_wr_i = 1'b0;
	logic               reg_rd_i = 1'b0;
	logic               rd_d = 1'b0;
	logic [15:0]        reg_rdata_o;
	logic [NSRC-1:0]    src_req_i = '0;
	logic [NSRC-1:0]    src_clr_o;
	logic [NSRC-1:0]    cpu_irq_o;
	logic               sw_irq_o;
	logic               busy_o;
	ett_mem_req_t       mem_req_o;
	ett_mem_rsp_t       mem_rsp_i;
	logic [31:0]        rq[$];
	logic [31:0]        vq[$];
	logic [31:0]        e;
	logic [31:0]        s;
	logic [31:0]        d;
	logic [15:0]        r;
	int                 failures = 0;
	int                 comparisons = 0;
	int                 sw_irqs = 0;
	int                 irqs_exp = 0;
	int                 clrs = 0;
	logic [15:0]        md [3] = '{16'hA000, 16'hC100, 16'hB220};
	logic [15:0]        cn [3] = '{16'h0001, 16'h0002, 16'h0003};
	logic               iq [3] = '{1'b1, 1'b0, 1'b1};
	logic [15:0]        hm [3] = '{16'hA040, 16'hA000, 16'hA000};
	logic [31:0]        ho [3] = '{32'h0000_0200, 32'h0000_0210, 32'h0000_0240};

	always #50 clk_i = ~clk_i;

	ett_engine i_dut
	(
		.clk_i(clk_i), .rst_i(rst_i), .standby_i(standby_i), .nmi_pin_i(nmi_pin_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .src_req_i(src_req_i),
		.src_clr_o(src_clr_o), .cpu_irq_o(cpu_irq_o), .sw_irq_o(sw_irq_o),
		.mem_req_o(mem_req_o), .mem_rsp_i(mem_rsp_i), .busy_o(busy_o)
	);
	ett_mem_model i_mem
	(
		.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .req_i(mem_req_o), .rsp_o(mem_rsp_i)
	);

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic done(input string n);
		$display("test %s finished", n);
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// the note is taken off the queue by the monitor in the answer cycle
	task automatic rd(input logic [3:0] a, input logic [15:0] v, input logic [15:0] mask);
		rq.push_back({v, mask});
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// idle must hold a while, so a gap between two activations is not taken as the end
	task automatic wait_idle();
		int k;
		int q;
		k = 0;
		q = 0;
		while (q < 6)
		begin
			@(posedge clk_i);
			q = (busy_o === 1'b0) ? q + 1 : 0;
			k++;
			if (k > 3000)
			begin
				check("busy timeout", 32'h0000_0001, 32'h0000_0000);
				end_of_test();
			end
		end
	endtask

	task automatic desc(input logic [31:0] at, input logic [15:0] m, input logic [15:0] c,
		input logic [31:0] sa, input logic [31:0] da);
		i_mem.put(at, {m, c}, 4);
		i_mem.put(at + 32'h0000_0008, sa, 4);
		i_mem.put(at + 32'h0000_000C, da, 4);
		i_mem.put(sa, $urandom, 4);
	endtask

	task automatic post(input logic [31:0] at, input logic [15:0] m, input logic [15:0] c,
		input logic [31:0] sa, input logic [31:0] da);
		logic [31:0] st;
		st = 32'h0000_0001 << m[9:8];
		check("count", i_mem.get(at, 4), {m, c - 16'h0001});
		check("src", i_mem.get(at + 32'h0000_0008, 4), m[15] ? (m[14] ? sa - st : sa + st) : sa);
		check("dst", i_mem.get(at + 32'h0000_000C, 4), m[13] ? (m[12] ? da - st : da + st) : da);
		check("data", i_mem.get(da, st), i_mem.get(sa, st));
	endtask

	always @(negedge clk_i)
	begin
		if (rd_d)
		begin
			e = rq.pop_front();
			check("reg read", {16'h0000, reg_rdata_o & e[15:0]}, {16'h0000, e[31:16] & e[15:0]});
		end
		rd_d = reg_rd_i;
		if (sw_irq_o === 1'b1)
			sw_irqs++;
		if (src_clr_o !== '0)
			clrs++;
		if (mem_req_o.valid && mem_rsp_i.ack && !mem_req_o.write && mem_req_o.addr[31:8] == 24'h00_0004)
			check("vector addr", mem_req_o.addr, vq.pop_front());
	end

	initial
	begin
		void'($urandom(32'h0000_edb9));
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int a = 0; a < 5; a++)
			rd(4'(a), 16'h0000, 16'hFFFF);
		rd(OFF_CSR, 16'h0000, 16'hFFFF);
		rd(4'hA, 16'h0000, 16'hFFFF);
		wr(OFF_BASE, 16'h0001);
		rd(OFF_BASE, 16'h0001, 16'hFFFF);
		r = 16'($urandom) & 16'h00FF;
		// the startup read armed this register; this write disarms it
		wr(4'h1, 16'h0000);
		wr(4'h1, 16'h00FF);
		rd(4'h1, 16'h0000, 16'hFFFF);
		wr(4'h1, r);
		rd(4'h1, r, 16'hFFFF);
		wr(4'h1, 16'h0000);
		rd(4'h1, 16'h0000, 16'hFFFF);
		wr(OFF_CSR, 16'hFE12);
		rd(OFF_CSR, 16'h0012, 16'hFFFF);
		done("registers");
		i_mem.put(32'h0000_0412, 32'h0000_0100, 2);
		for (int i = 0; i < 3; i++)
		begin
			s = 32'h0000_2000 + 32'(i) * 32'h0000_0040;
			d = s + 32'h0000_1000;
			desc(32'h0001_0100, md[i], cn[i], s, d);
			vq.push_back(32'h0000_0412);
			wr(OFF_CSR, 16'h0112);
			wait_idle();
			post(32'h0001_0100, md[i], cn[i], s, d);
			irqs_exp = irqs_exp + iq[i];
			check("sw irq", sw_irqs, irqs_exp);
			rd(OFF_CSR, iq[i] ? 16'h0112 : 16'h0012, 16'hFFFF);
		end
		wr(OFF_CSR, 16'h0034);
		rd(OFF_CSR, 16'h0012, 16'hFFFF);
		wr(OFF_CSR, 16'h0034);
		rd(OFF_CSR, 16'h0034, 16'hFFFF);
		// repeat: last count reloads the area side; block: area side returns to start
		desc(32'h0001_0100, 16'hA480, 16'h0201, 32'h0000_2100, 32'h0000_3100);
		i_mem.put(32'h0001_0104, 32'h0000_2400, 4);
		vq.push_back(32'h0000_0412);
		wr(OFF_CSR, 16'h0112);
		wait_idle();
		check("rep count", i_mem.get(32'h0001_0100, 4), 32'hA480_0202);
		check("rep src", i_mem.get(32'h0001_0108, 4), 32'h0000_2400);
		check("rep dst", i_mem.get(32'h0001_010C, 4), 32'h0000_3101);
		check("rep data", i_mem.get(32'h0000_3100, 1), i_mem.get(32'h0000_2100, 1));
		check("rep irq", sw_irqs, irqs_exp);
		desc(32'h0001_0100, 16'hA800, 16'h0001, 32'h0000_2140, 32'h0000_3140);
		i_mem.put(32'h0001_0104, 32'h0000_0002, 4);
		vq.push_back(32'h0000_0412);
		wr(OFF_CSR, 16'h0112);
		wait_idle();
		check("blk count", i_mem.get(32'h0001_0100, 4), 32'hA800_0000);
		check("blk src", i_mem.get(32'h0001_0108, 4), 32'h0000_2142);
		check("blk dst", i_mem.get(32'h0001_010C, 4), 32'h0000_3140);
		check("blk data", i_mem.get(32'h0000_3140, 2), i_mem.get(32'h0000_2140, 2));
		irqs_exp++;
		check("blk irq", sw_irqs, irqs_exp);
		done("software start");
		slow <= 1'b1;
		i_mem.put(32'h0000_0400, 32'h0000_0200, 2);
		i_mem.put(32'h0000_0402, 32'h0000_0240, 2);
		for (int i = 0; i < 3; i++)
			desc(32'h0001_0000 + ho[i], hm[i], 16'h0001, 32'h0000_2000 + ho[i], 32'h0000_3000 + ho[i]);
		rd(4'h0, 16'h0000, 16'hFFFF);
		wr(4'h0, 16'h00C0);
		vq.push_back(32'h0000_0400);
		vq.push_back(32'h0000_0402);
		src_req_i[7:6] <= 2'b11;
		wait_idle();
		for (int i = 0; i < 3; i++)
			post(32'h0001_0000 + ho[i], hm[i], 16'h0001, 32'h0000_2000 + ho[i], 32'h0000_3000 + ho[i]);
		check("cpu irq", {30'h0000_0000, cpu_irq_o[7:6]}, 32'h0000_0003);
		check("src clr", clrs, 0);
		src_req_i <= '0;
		rd(4'h0, 16'h0000, 16'hFFFF);
		done("sources");
		slow <= 1'b0;
		nmi_pin_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		nmi_pin_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		wr(OFF_CSR, 16'h0112);
		repeat (20) @(posedge clk_i);
		check("busy", {31'h0000_0000, busy_o}, 32'h0000_0000);
		rd(OFF_CSR, 16'h0512, 16'hFFFF);
		wr(OFF_CSR, 16'h0012);
		rd(OFF_CSR, 16'h0012, 16'hFFFF);
		desc(32'h0001_0100, 16'hA100, 16'h0001, 32'h0000_2001, 32'h0000_3000);
		vq.push_back(32'h0000_0412);
		wr(OFF_CSR, 16'h0112);
		wait_idle();
		rd(OFF_CSR, 16'h0200, 16'h0200);
		// a quiet cycle lets the blocking check see an idle engine with the flag up
		@(posedge clk_i);
		wr(OFF_CSR, 16'h0000);
		rd(OFF_CSR, 16'h0000, 16'h0200);
		done("flags");
		rd(4'h2, 16'h0000, 16'hFFFF);
		wr(4'h2, 16'h0081);
		rd(4'h2, 16'h0081, 16'hFFFF);
		standby_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		standby_i <= 1'b0;
		@(posedge clk_i);
		rd(4'h2, 16'h0000, 16'hFFFF);
		rd(OFF_CSR, 16'h0000, 16'hFFFF);
		rd(OFF_BASE, 16'h0001, 16'hFFFF);
		done("standby");
		end_of_test();
	end
endmodule
`default_nettype wire
